// ==== logic/two_wire_pkg.sv ====
`default_nettype none
package two_wire_pkg;
    // Register byte offsets
    localparam logic [3:0] STATUS_REG_OFS = 4'h0;
    localparam logic [3:0] CONTROL_REG_OFS = 4'h4;
    localparam logic [3:0] DATA_REG_OFS = 4'h8;
    localparam logic [3:0] OWN_ADDRESS_REG_OFS = 4'hC;

    // Control register bit positions
    localparam int IRQ_FLAG_BIT = 7;
    localparam int ACK_ENABLE_BIT = 6;
    localparam int START_REQUEST_BIT = 5;
    localparam int STOP_REQUEST_BIT = 4;
    localparam int UNIT_ENABLE_BIT = 2;

    // Own address register fields
    localparam int GENERAL_CALL_ENABLE_BIT = 0;
    localparam int OWN_SLAVE_ADDRESS_LSB = 1;

    // Status codes, prescaler bits zero
    localparam logic [7:0] ST_OWN_READ = 8'hA8;
    localparam logic [7:0] ST_ARB_LOST_READ = 8'hB0;
    localparam logic [7:0] ST_DATA_ACK = 8'hB8;
    localparam logic [7:0] ST_DATA_NACK = 8'hC0;
    localparam logic [7:0] ST_LAST_ACK = 8'hC8;
    localparam logic [7:0] ST_NO_INFO = 8'hF8;
    localparam logic [7:0] ST_BUS_ERROR = 8'h00;
    localparam logic [1:0] PRESCALER_MASK = 2'h3;

    // Reset values, general call address and last bit index
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [7:0] OWN_ADDRESS_RESET = 8'h00;
    localparam logic [7:0] GENERAL_CALL_ADDRESS = 8'h00;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_s;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_HOLD,
        S_TX,
        S_TX_ACK,
        S_ERROR
    } link_state_e;
endpackage
`default_nettype wire

// ==== logic/two_wire_slave_tx.sv ====
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_tx
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire two_wire_pkg::avmm_req_s avmm_req_in,
    output logic [31:0] avmm_readdata_out,
    output logic avmm_waitrequest_out,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic arb_lost_in,
    output logic start_req_out,
    output logic general_call_out,
    output logic irq_flag_out
);
    import two_wire_pkg::*;

    // Avalon slave: one wait cycle, then the answer
    logic ack_q;
    logic [31:0] rdata_q;
    logic req;
    logic do_write;
    logic ctrl_wr;
    logic [7:0] wdata;
    logic [7:0] status_value;

    assign req = avmm_req_in.read | avmm_req_in.write;
    assign avmm_waitrequest_out = req & ~ack_q;
    assign avmm_readdata_out = rdata_q;
    assign do_write = avmm_req_in.write & ack_q & avmm_req_in.byteenable[0];
    assign wdata = avmm_req_in.writedata[7:0];
    assign ctrl_wr = do_write & (avmm_req_in.address == CONTROL_REG_OFS);

    logic irq_q;
    logic [7:0] code_q;
    logic ack_en_q;
    logic start_q;
    logic stop_q;
    logic en_q;
    logic [7:0] data_q;
    logic [7:0] own_q;

    // Status low bits are the prescaler, always zero
    assign status_value = (irq_q ? code_q : ST_NO_INFO) & ~{6'h00, PRESCALER_MASK};

    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            rdata_q <= 32'h0000_0000;
            if (avmm_req_in.read & ~ack_q)
            begin
                case (avmm_req_in.address)
                    STATUS_REG_OFS: rdata_q <= {24'h00_0000, status_value};
                    CONTROL_REG_OFS: rdata_q <= {24'h00_0000, irq_q, ack_en_q, start_q, stop_q,
                        1'b0, en_q, 2'b00};
                    DATA_REG_OFS: rdata_q <= {24'h00_0000, data_q};
                    OWN_ADDRESS_REG_OFS: rdata_q <= {24'h00_0000, own_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin synchronisers: a level counts once stages two and three agree
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [1:0] pin_q;
    logic [1:0] pin_prev_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            sync1_q <= 2'b11;
            sync2_q <= 2'b11;
            sync3_q <= 2'b11;
            pin_q <= 2'b11;
            pin_prev_q <= 2'b11;
        end
        else
        begin
            sync1_q <= {scl_in, sda_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q[1] == sync3_q[1])
                pin_q[1] <= sync3_q[1];
            if (sync2_q[0] == sync3_q[0])
                pin_q[0] <= sync3_q[0];
            pin_prev_q <= pin_q;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = pin_q[1] & ~pin_prev_q[1];
    assign scl_fall = ~pin_q[1] & pin_prev_q[1];
    assign start_det = pin_q[1] & pin_prev_q[1] & ~pin_q[0] & pin_prev_q[0];
    assign stop_det = pin_q[1] & pin_prev_q[1] & pin_q[0] & ~pin_prev_q[0];

    // Link engine
    link_state_e state_q;
    logic [2:0] cnt_q;
    logic addr_done_q;
    logic [7:0] shift_q;
    logic sda_low_q;
    logic last_q;
    logic ack_seen_q;
    logic arb_q;
    logic bus_busy_q;
    logic own_hit;
    logic gc_hit;
    logic in_frame;
    logic bus_err;
    logic irq_clear;
    logic recovery;
    logic tx_status;
    logic end_status;
    logic irq_set;
    logic [7:0] set_code;

    assign own_hit = ack_en_q & (shift_q[7:1] == own_q[7:OWN_SLAVE_ADDRESS_LSB])
        & shift_q[0];
    assign gc_hit = ack_en_q & own_q[GENERAL_CALL_ENABLE_BIT]
        & (shift_q == GENERAL_CALL_ADDRESS);
    assign in_frame = (state_q == S_ADDR && (cnt_q != 3'h0 || addr_done_q))
        || state_q == S_ADDR_ACK || state_q == S_TX || state_q == S_TX_ACK;
    assign bus_err = en_q & (start_det | stop_det) & in_frame;
    assign irq_clear = ctrl_wr & wdata[IRQ_FLAG_BIT];
    assign recovery = irq_clear & wdata[STOP_REQUEST_BIT] & (state_q == S_ERROR);
    assign tx_status = code_q == ST_OWN_READ || code_q == ST_ARB_LOST_READ
        || code_q == ST_DATA_ACK;
    assign end_status = code_q == ST_DATA_NACK || code_q == ST_LAST_ACK;

    always_comb
    begin
        irq_set = 1'b0;
        set_code = ST_NO_INFO;
        if (bus_err)
        begin
            irq_set = 1'b1;
            set_code = ST_BUS_ERROR;
        end
        else if (state_q == S_ADDR_ACK && scl_fall)
        begin
            irq_set = 1'b1;
            set_code = arb_q ? ST_ARB_LOST_READ : ST_OWN_READ;
        end
        else if (state_q == S_TX_ACK && scl_fall)
        begin
            irq_set = 1'b1;
            if (!ack_seen_q)
                set_code = ST_DATA_NACK;
            else if (last_q)
                set_code = ST_LAST_ACK;
            else
                set_code = ST_DATA_ACK;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= S_IDLE;
            cnt_q <= 3'h0;
            addr_done_q <= 1'b0;
            shift_q <= 8'h00;
            sda_low_q <= 1'b0;
            last_q <= 1'b0;
            ack_seen_q <= 1'b0;
            arb_q <= 1'b0;
            general_call_out <= 1'b0;
        end
        else
        begin
            general_call_out <= 1'b0;
            if (!en_q)
            begin
                state_q <= S_IDLE;
                sda_low_q <= 1'b0;
            end
            else if (bus_err)
            begin
                state_q <= S_ERROR;
                sda_low_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        // Not addressed: the bus is watched, never driven
                        sda_low_q <= 1'b0;
                        if (start_det)
                        begin
                            state_q <= S_ADDR;
                            cnt_q <= 3'h0;
                            addr_done_q <= 1'b0;
                        end
                    end
                    S_ADDR:
                    begin
                        if (start_det)
                        begin
                            cnt_q <= 3'h0;
                            addr_done_q <= 1'b0;
                        end
                        else if (stop_det)
                            state_q <= S_IDLE;
                        else if (scl_rise && !addr_done_q)
                        begin
                            shift_q <= {shift_q[6:0], pin_q[0]};
                            cnt_q <= cnt_q + 3'h1;
                            addr_done_q <= cnt_q == LAST_BIT_INDEX;
                        end
                        else if (scl_fall && addr_done_q)
                        begin
                            general_call_out <= gc_hit;
                            if (own_hit)
                            begin
                                state_q <= S_ADDR_ACK;
                                sda_low_q <= 1'b1;
                                arb_q <= arb_lost_in;
                            end
                            else
                                state_q <= S_IDLE;
                        end
                    end
                    S_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state_q <= S_HOLD;
                            sda_low_q <= 1'b0;
                        end
                    end
                    S_HOLD:
                    begin
                        if (irq_clear && tx_status)
                        begin
                            state_q <= S_TX;
                            shift_q <= data_q;
                            sda_low_q <= ~data_q[7];
                            cnt_q <= 3'h0;
                            last_q <= ~wdata[ACK_ENABLE_BIT];
                        end
                        else if (irq_clear && end_status)
                            state_q <= S_IDLE;
                    end
                    S_TX:
                    begin
                        if (scl_fall)
                        begin
                            cnt_q <= cnt_q + 3'h1;
                            if (cnt_q == LAST_BIT_INDEX)
                            begin
                                state_q <= S_TX_ACK;
                                sda_low_q <= 1'b0;
                            end
                            else
                            begin
                                shift_q <= {shift_q[6:0], 1'b1};
                                sda_low_q <= ~shift_q[6];
                            end
                        end
                    end
                    S_TX_ACK:
                    begin
                        if (scl_rise)
                            ack_seen_q <= ~pin_q[0];
                        else if (scl_fall)
                            state_q <= S_HOLD;
                    end
                    S_ERROR:
                    begin
                        sda_low_q <= 1'b0;
                        if (recovery)
                            state_q <= S_IDLE;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // Bus busy between START and STOP
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
            bus_busy_q <= 1'b0;
        else if (start_det)
            bus_busy_q <= 1'b1;
        else if (stop_det)
            bus_busy_q <= 1'b0;
    end

    // Software registers; hardware set of the flag wins over a clear
    always_ff @(posedge ref_clk_in)
    begin
        if (!reset_n_in)
        begin
            irq_q <= 1'b0;
            code_q <= ST_NO_INFO;
            ack_en_q <= CONTROL_RESET[ACK_ENABLE_BIT];
            start_q <= CONTROL_RESET[START_REQUEST_BIT];
            stop_q <= CONTROL_RESET[STOP_REQUEST_BIT];
            en_q <= CONTROL_RESET[UNIT_ENABLE_BIT];
            data_q <= DATA_RESET;
            own_q <= OWN_ADDRESS_RESET;
            start_req_out <= 1'b0;
        end
        else
        begin
            start_req_out <= 1'b0;
            if (irq_set)
            begin
                irq_q <= 1'b1;
                code_q <= set_code;
            end
            else if (irq_clear)
                irq_q <= 1'b0;
            if (ctrl_wr)
            begin
                ack_en_q <= wdata[ACK_ENABLE_BIT];
                start_q <= wdata[START_REQUEST_BIT];
                stop_q <= wdata[STOP_REQUEST_BIT] & ~recovery;
                en_q <= wdata[UNIT_ENABLE_BIT];
            end
            else if (start_q && !irq_q && !bus_busy_q && state_q == S_IDLE)
            begin
                start_req_out <= 1'b1;
                start_q <= 1'b0;
            end
            if (do_write && avmm_req_in.address == DATA_REG_OFS)
                data_q <= wdata;
            if (do_write && avmm_req_in.address == OWN_ADDRESS_REG_OFS)
                own_q <= wdata;
        end
    end

    // Open-drain pins: only ever pulled low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = irq_q & en_q & (code_q != ST_BUS_ERROR);
    assign sda_oe_out = sda_low_q;
    assign irq_flag_out = irq_q;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_idle_status_f8: assert property (!irq_q |-> status_value == ST_NO_INFO)
        else $error("status not F8 while flag clear");
    a_own_read_code: assert property (state_q == S_ADDR_ACK && scl_fall && !bus_err && !arb_q
        |=> irq_q && code_q == ST_OWN_READ && state_q != S_ADDR_ACK)
        else $error("own read did not report A8");
    a_arb_read_code: assert property (state_q == S_ADDR_ACK && scl_fall && !bus_err && arb_q
        |=> irq_q && code_q == ST_ARB_LOST_READ)
        else $error("arbitration loss did not report B0");
    a_data_ack_code: assert property (state_q == S_TX_ACK && scl_fall && !bus_err
        && ack_seen_q && !last_q |=> irq_q && code_q == ST_DATA_ACK)
        else $error("acked byte did not report B8");
    a_data_nack_code: assert property (state_q == S_TX_ACK && scl_fall && !bus_err
        && !ack_seen_q |=> irq_q && code_q == ST_DATA_NACK)
        else $error("nacked byte did not report C0");
    a_last_ack_code: assert property (state_q == S_TX_ACK && scl_fall && !bus_err
        && ack_seen_q && last_q |=> code_q == ST_LAST_ACK)
        else $error("acked last byte did not report C8");
    a_tx_last_flag: assert property (state_q == S_HOLD && irq_clear && tx_status && en_q
        && !bus_err |=> state_q == S_TX && last_q == !ack_en_q && !irq_q)
        else $error("last byte marking does not follow ack enable");
    a_end_unaddressed: assert property (state_q == S_HOLD && irq_clear && end_status && en_q
        && !bus_err |=> state_q == S_IDLE ##1 !sda_oe_out)
        else $error("did not return to not addressed state");
    a_bus_error_flag: assert property (bus_err |=> irq_q && code_q == ST_BUS_ERROR
        && !scl_oe_out && !sda_oe_out)
        else $error("bus error not flagged with code 00");
    a_recovery_release: assert property (recovery && en_q |=> state_q == S_IDLE && !stop_q
        && !irq_q ##1 !sda_oe_out && !scl_oe_out)
        else $error("bus error recovery incomplete");
    a_hold_scl_low: assert property (state_q == S_HOLD && irq_q && en_q |-> scl_oe_out)
        else $error("SCL not held while flag set");
    a_start_after_free: assert property (start_req_out |-> $past(start_q) && !bus_busy_q)
        else $error("start issued while bus busy");
    a_prescaler_zero: assert property (avmm_req_in.read && ack_q
        && avmm_req_in.address == STATUS_REG_OFS |-> avmm_readdata_out[1:0] == 2'b00)
        else $error("prescaler bits not zero");

    c_own_read: cover property (irq_q && code_q == ST_OWN_READ);
    c_data_nack: cover property (irq_q && code_q == ST_DATA_NACK);
    c_last_ack: cover property (irq_q && code_q == ST_LAST_ACK);
    c_bus_error: cover property (recovery);
endmodule
`default_nettype wire

// ==== tb/two_wire_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model
(
    input wire logic ref_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    initial
    begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    // Releases SCL, then waits while the slave stretches the low phase
    task automatic rise_scl();
        int n;
        n = 0;
        scl_low_out <= 1'b0;
        tick(1);
        while (scl_in !== 1'b1 && n < 5000)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic put_bit(input logic b);
        tick(5);
        sda_low_out <= ~b;
        tick(5);
        rise_scl();
        tick(9);
        scl_low_out <= 1'b1;
    endtask

    task automatic get_bit(output logic b);
        tick(5);
        sda_low_out <= 1'b0;
        tick(5);
        rise_scl();
        tick(4);
        b = sda_in;
        tick(5);
        scl_low_out <= 1'b1;
    endtask

    task automatic start();
        sda_low_out <= 1'b1;
        tick(10);
        scl_low_out <= 1'b1;
    endtask

    task automatic stop();
        tick(5);
        sda_low_out <= 1'b1;
        tick(5);
        rise_scl();
        tick(10);
        sda_low_out <= 1'b0;
        tick(20);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= 0; i--)
            put_bit(b[i]);
        get_bit(ack_n);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            get_bit(b[i]);
        put_bit(nack);
    endtask
endmodule
`default_nettype wire

// ==== tb/two_wire_slave_tx_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_tx_tb_top;
    import two_wire_pkg::*;
    logic ref_clk_in;
    logic reset_n_in;
    avmm_req_s req;
    logic [31:0] rdata;
    logic wait_req;
    logic scl_oe;
    logic sda_oe;
    logic m_scl_low;
    logic m_sda_low;
    logic arb_lost;
    logic start_req;
    logic irq;
    logic gc;
    wire scl_wire;
    wire sda_wire;
    int err_total;
    int check_count;
    int start_seen;
    int gc_seen;
    logic [7:0] v;
    logic a;

    assign scl_wire = ~(scl_oe | m_scl_low);
    assign sda_wire = ~(sda_oe | m_sda_low);

    two_wire_slave_tx i_two_wire_slave_tx (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .avmm_req_in(req), .avmm_readdata_out(rdata), .avmm_waitrequest_out(wait_req),
        .scl_in(scl_wire), .sda_in(sda_wire), .scl_out(), .scl_oe_out(scl_oe), .sda_out(),
        .sda_oe_out(sda_oe), .arb_lost_in(arb_lost), .start_req_out(start_req),
        .general_call_out(gc), .irq_flag_out(irq));

    two_wire_master_model i_two_wire_master_model (.ref_clk_in(ref_clk_in), .scl_in(scl_wire),
        .sda_in(sda_wire), .scl_low_out(m_scl_low), .sda_low_out(m_sda_low));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
        if (start_req === 1'b1)
            start_seen++;

    always @(posedge ref_clk_in)
        if (gc === 1'b1)
            gc_seen++;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        req.read <= ~wr;
        req.write <= wr;
        req.address <= ad;
        req.writedata <= {24'h00_0000, wd};
        req.byteenable <= 4'hF;
        @(posedge ref_clk_in);
        while (wait_req !== 1'b0 && n < 100)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 100)
            err_total++;
        v = rdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
        bus(1'b0, ad, 8'h00);
        chk(v, exp);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        chk({7'h00, irq}, 8'h01);
    endtask

    task automatic addr(input logic [7:0] b, input logic ack_n);
        i_two_wire_master_model.start();
        i_two_wire_master_model.send_byte(b, a);
        chk({7'h00, a}, {7'h00, ack_n});
    endtask

    initial
    begin
        req = '0;
        reset_n_in = 1'b0;
        arb_lost = 1'b0;
        err_total = 0;
        check_count = 0;
        start_seen = 0;
        gc_seen = 0;
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        rd(STATUS_REG_OFS, ST_NO_INFO);
        rd(CONTROL_REG_OFS, CONTROL_RESET);
        rd(DATA_REG_OFS, DATA_RESET);
        rd(OWN_ADDRESS_REG_OFS, OWN_ADDRESS_RESET);
        rd(4'h2, 8'h00);
        bus(1'b1, OWN_ADDRESS_REG_OFS, 8'h55);
        rd(OWN_ADDRESS_REG_OFS, 8'h55);
        bus(1'b1, CONTROL_REG_OFS, 8'h44);
        rd(CONTROL_REG_OFS, 8'h44);
        $display("test registers done");

        addr(8'h55, 1'b0);
        wait_irq();
        rd(STATUS_REG_OFS, ST_OWN_READ);
        chk({7'h00, scl_oe}, 8'h01);
        bus(1'b1, DATA_REG_OFS, 8'h5A);
        bus(1'b1, CONTROL_REG_OFS, 8'hC4);
        i_two_wire_master_model.recv_byte(1'b0, v);
        chk(v, 8'h5A);
        wait_irq();
        rd(STATUS_REG_OFS, ST_DATA_ACK);
        bus(1'b1, DATA_REG_OFS, 8'h3C);
        bus(1'b1, CONTROL_REG_OFS, 8'h84);
        i_two_wire_master_model.recv_byte(1'b0, v);
        chk(v, 8'h3C);
        wait_irq();
        rd(STATUS_REG_OFS, ST_LAST_ACK);
        bus(1'b1, CONTROL_REG_OFS, 8'h84);
        rd(STATUS_REG_OFS, ST_NO_INFO);
        i_two_wire_master_model.recv_byte(1'b1, v);
        chk(v, 8'hFF);
        i_two_wire_master_model.stop();
        $display("test transmit done");

        bus(1'b1, CONTROL_REG_OFS, 8'h44);
        arb_lost <= 1'b1;
        addr(8'h55, 1'b0);
        wait_irq();
        rd(STATUS_REG_OFS, ST_ARB_LOST_READ);
        arb_lost <= 1'b0;
        bus(1'b1, DATA_REG_OFS, 8'h81);
        bus(1'b1, CONTROL_REG_OFS, 8'h84);
        i_two_wire_master_model.recv_byte(1'b1, v);
        chk(v, 8'h81);
        wait_irq();
        rd(STATUS_REG_OFS, ST_DATA_NACK);
        start_seen = 0;
        bus(1'b1, CONTROL_REG_OFS, 8'hE4);
        i_two_wire_master_model.stop();
        for (int n = 0; n < 200 && start_seen == 0; n++)
            @(posedge ref_clk_in);
        chk(start_seen[7:0], 8'h01);
        rd(CONTROL_REG_OFS, 8'h44);
        addr(8'h55, 1'b0);
        wait_irq();
        rd(STATUS_REG_OFS, ST_OWN_READ);
        bus(1'b1, CONTROL_REG_OFS, 8'h84);
        i_two_wire_master_model.recv_byte(1'b1, v);
        wait_irq();
        rd(STATUS_REG_OFS, ST_DATA_NACK);
        bus(1'b1, CONTROL_REG_OFS, 8'h84);
        i_two_wire_master_model.stop();
        addr(8'h55, 1'b1);
        i_two_wire_master_model.stop();
        $display("test arbitration done");

        bus(1'b1, CONTROL_REG_OFS, 8'h44);
        addr(8'h00, 1'b1);
        i_two_wire_master_model.stop();
        chk(gc_seen[7:0], 8'h01);
        i_two_wire_master_model.start();
        for (int n = 0; n < 3; n++)
            i_two_wire_master_model.put_bit(1'b1);
        i_two_wire_master_model.stop();
        wait_irq();
        rd(STATUS_REG_OFS, ST_BUS_ERROR);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        bus(1'b1, CONTROL_REG_OFS, 8'hD4);
        rd(CONTROL_REG_OFS, 8'h44);
        rd(STATUS_REG_OFS, ST_NO_INFO);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        $display("test bus error done");
        summarize();
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk_in);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
